// >>> verif/smt_mst.sv
// smbus master model driving the two-wire pins
`timescale 1ns/100ps
module smt_mst (
  input  wire logic clock, scl, sda,
  output logic      scl_pd = 1'h0, sda_pd = 1'h0, tmo = 1'h0
);
  // release scl, bounded wait for a stretch to end
  task automatic up();
    scl_pd <= 1'h0;
    for (int i = 0; i < 400 && !scl; i++) @(posedge clock);
    if (!scl) tmo <= 1'h1;
    repeat (3) @(posedge clock);
  endtask : up
  // data moves only while scl is low
  task automatic bit_io(input logic b, output logic r);
    sda_pd <= ~b;
    repeat (8) @(posedge clock);
    up();
    r = sda;
    scl_pd <= 1'h1;
    repeat (2) @(posedge clock);
  endtask : bit_io
  // st=1 start or repeated start, st=0 stop
  task automatic cond(input logic st);
    sda_pd <= ~st;
    repeat (6) @(posedge clock);
    up();
    sda_pd <= st;
    repeat (6) @(posedge clock);
    scl_pd <= st;
    repeat (2) @(posedge clock);
  endtask : cond
  // whole byte then ack bit; pec bit clear, no crc byte
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, r);
  endtask : byte_io
endmodule : smt_mst

// >>> verif/smt_sva.sv
// assertions on the smbus target port pins
`timescale 1ns/100ps
module smt_sva #(parameter int unsigned PORT_NUM = 1) (
  input wire logic                   clock, rst_n, scl_val, sda_val, port_mem, port_hotplug,
  input wire logic [1:0]             port_channel,
  input wire logic                   ring_clk, ring_rst_n, ring_valid, ring_ack, hbus_req, hbus_gnt,
  input wire smt_pkg::smt_ring_cmd_s ring_cmd
);
  // the ring took the access
  sequence s_acked;
    ring_valid && ring_ack;
  endsequence
  chk_scl_val_low: assert property (@(posedge clock) disable iff (!rst_n) !scl_val)
    else $error("scl high");
  chk_sda_val_low: assert property (@(posedge clock) disable iff (!rst_n) !sda_val)
    else $error("sda high");
  chk_role_chan: assert property (@(posedge clock) disable iff (!rst_n) $past(rst_n) |->
    port_channel == 2'(PORT_NUM - 1)) else $error("bad channel");
  chk_role_kind: assert property (@(posedge clock) disable iff (!rst_n) $past(rst_n) |->
    port_mem == (PORT_NUM <= 4) && port_hotplug == (PORT_NUM == 6)) else $error("bad role");
  chk_req_hold: assert property (@(posedge ring_clk) disable iff (!ring_rst_n)
    ring_valid && !ring_ack |=> ring_valid && $stable(ring_cmd)) else $error("request moved");
  chk_req_done: assert property (@(posedge ring_clk) disable iff (!ring_rst_n) s_acked |=> !ring_valid)
    else $error("request stuck");
  chk_gnt_excl: assert property (@(posedge ring_clk) disable iff (!ring_rst_n) !(ring_valid && hbus_gnt))
    else $error("two owners");
  chk_host_keep: assert property (@(posedge ring_clk) disable iff (!ring_rst_n) hbus_gnt && hbus_req |=> hbus_gnt)
    else $error("host lost ring");
endmodule : smt_sva
bind smt_target_port smt_sva #(.PORT_NUM(PORT_NUM)) u_sva (.clock, .rst_n, .scl_val, .sda_val, .port_mem,
  .port_hotplug, .port_channel, .ring_clk, .ring_rst_n, .ring_valid, .ring_ack, .hbus_req, .hbus_gnt, .ring_cmd);

// >>> verif/tb.sv
// bench for the smbus target config port
`timescale 1ns/100ps
module tb;
  logic clock = 1'h0, ring_clk = 1'h0, rst_n = 1'h0, hbus_req = 1'h0, ring_ack = 1'h0, go = 1'h1;
  logic m_scl, m_sda, n, scl_oe, sda_oe, ring_valid, hbus_gnt;
  logic [7:0] b;
  wire [4:0] rl;
  int err_count = 0, checks_done = 0, n_acc = 0;
  smt_pkg::smt_ring_cmd_s ring_cmd, got;
  smt_pkg::smt_ring_rsp_s ring_rsp = {32'h5a3c9617, 2'h0};
  wire scl = ~(m_scl | scl_oe);
  wire sda = ~(m_sda | sda_oe);
  initial forever #25 clock = ~clock;
  initial begin
    #7;
    forever #16 ring_clk = ~ring_clk;
  end
  smt_target_port #(.PORT_NUM(1), .TIMEOUT_CYCLES(200)) u_dut (.clock, .rst_n, .ce(1'h1), .scl, .scl_val(),
    .scl_oe, .sda, .sda_val(), .sda_oe, .port_channel(rl[4:3]), .port_mem(rl[2]), .port_hotplug(rl[1]),
    .busy(rl[0]), .ring_clk, .ring_rst_n(rst_n), .ring_cmd, .ring_valid, .ring_ack, .ring_rsp, .hbus_req, .hbus_gnt);
  smt_mst u_mst (.clock, .scl, .sda, .scl_pd(m_scl), .sda_pd(m_sda), .tmo());
  // ring slave answers at once unless held off to fake a hang
  always @(posedge ring_clk) begin
    ring_ack <= ring_valid && !ring_ack && go;
    if (ring_valid && !ring_ack && go) begin
      got <= ring_cmd;
      n_acc <= n_acc + 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  // one write transfer, every byte expecting the same answer
  task automatic xfer(input logic [7:0] q[$], input logic nak);
    u_mst.cond(1'h1);
    foreach (q[i]) begin
      u_mst.byte_io(q[i], 1'h1, b, n);
      chk("ack", n, nak);
    end
    u_mst.cond(1'h0);
  endtask : xfer
  initial begin
    repeat (10) @(posedge clock);
    chk("idle", {scl_oe, sda_oe}, 0);
    rst_n <= 1'h1;
    repeat (5) @(posedge clock);
    for (int op = 1; op < 4; op++) begin
      xfer('{8'h60, 8'(8'he2 | op << 2), 8'h08, 8'h00, 8'h09, 8'h01, 8'h46, 8'h11, 8'h22, 8'h33, 8'h44}, 1'h0);
      chk("be", got.be, op == 1 ? 4'h4 : op == 2 ? 4'hc : 4'hf);
      chk("offset", got.offset, op == 3 ? 24'h144 : 24'h146);
      chk("fields", {got.cfg, got.write, got.dev, got.fn, got.wdata[7:0]}, {2'h3, 5'h01, 3'h1, 8'h44});
    end
    chk("wdata", got.wdata, 32'h11223344);
    for (int m = 0; m < 2; m++) begin
      xfer('{8'h60, m ? 8'he2 : 8'hc2, 8'h04, m ? 8'h00 : 8'h20, m ? 8'h09 : 8'h00, m ? 8'h01 : 8'h12,
        m ? 8'h46 : 8'h37}, 1'h0);
      chk("mode", {got.cfg, got.region, got.write, got.offset}, {m[0], m ? 3'h0 : 3'h1, 1'h0, m ? 24'h144 : 24'h1234});
      u_mst.cond(1'h1);
      u_mst.byte_io(8'h61, 1'h1, b, n);
      for (int i = 0; i < 6; i++) begin
        u_mst.byte_io(8'hff, i == 5, b, n);
        chk("rdata", b, 8'({8'h05, 8'h01, 32'h5a3c9617} >> (8 * (5 - i))));
      end
      u_mst.cond(1'h0);
    end
    xfer('{8'h62}, 1'h1);
    xfer('{8'h60, 8'he2, 8'h04, 8'h00}, 1'h0);
    chk("launches", n_acc, 5);
    go <= 1'h0;
    xfer('{8'h60, 8'hee, 8'h08, 8'h00, 8'h09, 8'h01, 8'h44, 8'h01, 8'h02, 8'h03, 8'h04}, 1'h0);
    xfer('{8'h60}, 1'h1);
    go <= 1'h1;
    for (int i = 0; i < 300 && n_acc < 6; i++) @(posedge clock);
    chk("late", n_acc, 6);
    u_mst.cond(1'h1);
    for (int i = 0; i < 3; i++) u_mst.byte_io(i ? 8'hff : 8'h61, i != 1, b, n);
    chk("timeout", b, 8'h80);
    u_mst.cond(1'h0);
    chk("stretch", u_mst.tmo, 1'h0);
    @(posedge ring_clk) hbus_req <= 1'h1;
    repeat (8) @(posedge ring_clk);
    chk("host", hbus_gnt, 1'h1);
    chk("role", rl, 5'h04);
    close_out();
  end
endmodule : tb

// >>> verilog/smt_pkg.sv
// shared constants, types and helpers for the smbus target config port
package smt_pkg;

  // own 7-bit target address, fixed in hardware
  localparam logic [6:0] OWN_ADDR = 7'h30;

  // command byte bit positions
  localparam int CMD_BEGIN = 7;
  localparam int CMD_END   = 6;
  localparam int CMD_MODE  = 5;
  localparam int CMD_PEC   = 4;

  // internal operation, command bits 3:2
  localparam logic [1:0] OP_RD_DWORD = 2'h0;
  localparam logic [1:0] OP_WR_BYTE  = 2'h1;
  localparam logic [1:0] OP_WR_WORD  = 2'h2;
  localparam logic [1:0] OP_WR_DWORD = 2'h3;

  // bus transfer size, command bits 1:0 (3 is reserved)
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_WORD  = 2'h1;
  localparam logic [1:0] SZ_DWORD = 2'h2;

  // read result byte bit positions
  localparam int STS_TIMEOUT = 7;
  localparam int STS_MABORT  = 5;
  localparam int STS_TABORT  = 4;
  localparam int STS_OK      = 0;

  // field pointer limits: four address bytes, then four data bytes
  localparam logic [3:0] FLD_ADDR_END = 4'h4;
  localparam logic [3:0] FLD_ALL_END  = 4'h8;

  // read answer: length byte (status plus four data), then status, payload_byte_3..0
  localparam logic [7:0] RD_BLOCK_LEN = 8'h05;
  localparam logic [2:0] TX_IDX_LEN   = 3'h0;
  localparam logic [2:0] TX_IDX_STS   = 3'h1;
  localparam logic [2:0] TX_IDX_MAX   = 3'h7;
  localparam logic [7:0] TX_FILL      = 8'hff;

  // timing at the core clock
  localparam int CLK_PERIOD_NS  = 50;
  localparam int TIMEOUT_NS     = 2000000;
  localparam int TIMEOUT_CYC    = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int STRETCH_MAX_NS = 25000000;

  // port roles: ports 1..4 serve channels 0..3, port 6 serves hot-plug
  localparam int PORT_COUNT    = 6;
  localparam int MEM_PORT_LAST = 4;
  localparam int HOTPLUG_PORT  = 6;

  // byte engine states
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK0, ST_ACK1, ST_TX, ST_MACK, ST_HOLD
  } smt_state_e;

  // which field the next written byte lands in
  typedef enum logic [1:0] {PH_CMD, PH_CNT, PH_FLD} smt_phase_e;

  // access handed to the configuration ring
  typedef struct packed {
    logic        cfg;
    logic [2:0]  region;
    logic [4:0]  bus;
    logic [4:0]  dev;
    logic [2:0]  fn;
    logic [23:0] offset;
    logic        write;
    logic [3:0]  be;
    logic [31:0] wdata;
  } smt_ring_cmd_s;

  // answer from the configuration ring
  typedef struct packed {
    logic [31:0] rdata;
    logic        mabort;
    logic        tabort;
  } smt_ring_rsp_s;

  // core-domain engine state, all zero after reset
  typedef struct packed {
    smt_state_e      st;
    smt_phase_e      phase;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic            is_addr;
    logic            rd;
    logic            ack;
    logic            mack;
    logic            cmd_seen;
    logic            launch;
    logic [7:0]      cmd;
    logic [7:0]      len;
    logic [0:7][7:0] fld;
    logic [3:0]      ptr;
    logic [2:0]      tx_idx;
    logic [7:0]      sts;
    logic [31:0]     rdata;
    logic            req_tog;
    logic            issued;
    logic            busy;
    logic            scl_p;
    logic            sda_p;
    logic            scl_oe;
    logic            sda_oe;
  } smt_core_s;

  // byte lanes touched by an aligned access
  function automatic logic [3:0] smt_byte_en(input logic [1:0] op, input logic [1:0] lo);
    logic [3:0] be;
    be = 4'hf;
    if (op == OP_WR_BYTE) be = 4'h1 << lo;
    else if (op == OP_WR_WORD) be = lo[1] ? 4'hc : 4'h3;
    return be;
  endfunction : smt_byte_en

endpackage : smt_pkg

// >>> verilog/smt_ring_arb.sv
// first-come arbiter between this port and the host processor bus
`timescale 1ns/100ps
module smt_ring_arb (
  // ring clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // requests
  input  wire logic port_req,
  input  wire logic port_done,
  input  wire logic hbus_req,
  // grants
  output logic      port_gnt_q,
  output logic      hbus_gnt_q
);

  typedef enum logic [1:0] {OWN_NONE, OWN_HOST, OWN_PORT} smt_own_e;

  smt_own_e own_q; // current owner of the ring
  smt_own_e own_d;

  // owner keeps the ring until it lets go; an idle ring goes to whoever asks first
  always_comb begin
    own_d = own_q;
    unique case (own_q)
      // R12 first come, tie to host
      OWN_NONE: begin
        if (hbus_req) own_d = OWN_HOST;
        else if (port_req) own_d = OWN_PORT;
      end
      OWN_HOST: begin
        if (!hbus_req) own_d = OWN_NONE;
      end
      OWN_PORT: begin
        if (port_done) own_d = OWN_NONE;
      end
      default: own_d = OWN_NONE;
    endcase
  end

  // owner and grant flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      own_q      <= OWN_NONE;
      port_gnt_q <= 1'b0;
      hbus_gnt_q <= 1'b0;
    end else begin
      own_q      <= own_d;
      port_gnt_q <= (own_d == OWN_PORT);
      hbus_gnt_q <= (own_d == OWN_HOST);
    end
  end

endmodule : smt_ring_arb

// >>> verilog/smt_sync.sv
// two-stage synchroniser for levels and toggles
`timescale 1ns/100ps
module smt_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and control
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q; // first stage, read only by the second

  // plain two flops, nothing taps the first stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else if (en) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : smt_sync

// >>> verilog/smt_target_port.sv
// smbus target port giving a management master access to the config ring
//
// Functional notes
// R01 - six identical revision 2.0 two-wire target ports
// R02 - ports 1-4 serve channels 0-3, 6 hot-plug
// R03 - detect start, then match own 7-bit address
// R04 - own address hard-wired to 60h
// R05 - abandoned sequence returns cleanly to idle
// R06 - stretch clock while access pending, under 25ms
// R07 - a command byte with its end bit can start an access; the final needed address or data byte also launches one
// R08 - NAK all traffic while a command runs
// R09 - master writes four address bytes, then data
// R10 - config mode: bus, devfn, extended, offset fields
// R11 - memory mode: region, zero filler, region address
// R12 - ring served first-come; tie goes to host
// R13 - port progresses even if ring hangs
// R14 - byte order: command, count, address, data, status
// R15 - fields loaded only from received bus traffic
// R16 - command bit 7 first, bit 6 last
// R17 - command bit 5: 0 memory, 1 config
// R18 - error code bit unsupported, no crc byte
// R19 - bits 3:2: read dword, write byte/word/dword
// R20 - internal accesses naturally aligned to width
// R21 - bits 1:0 give bus transfer size
// R22 - read returns status byte before the data
// R23 - byte count only in block transfers
// R24 - reads return dword; writes use low lanes
// R25 - address byte 3: bus zero or region
// R26 - abandon before command: no access launched
`timescale 1ns/100ps
module smt_target_port #(
  parameter int unsigned PORT_NUM       = 1,
  parameter int unsigned TIMEOUT_CYCLES = smt_pkg::TIMEOUT_CYC
) (
  // core clock domain
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire logic           ce,
  // two-wire bus pins, open drain
  input  wire logic           scl,
  output logic                scl_val,
  output logic                scl_oe,
  input  wire logic           sda,
  output logic                sda_val,
  output logic                sda_oe,
  // port role
  output logic [1:0]          port_channel,
  output logic                port_mem,
  output logic                port_hotplug,
  output logic                busy,
  // configuration ring, ring clock domain
  input  wire logic           ring_clk,
  input  wire logic           ring_rst_n,
  output smt_pkg::smt_ring_cmd_s ring_cmd,
  output logic                ring_valid,
  input  wire logic           ring_ack,
  input  wire smt_pkg::smt_ring_rsp_s ring_rsp,
  // host processor bus competing for the ring
  input  wire logic           hbus_req,
  output logic                hbus_gnt
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  // elaboration checks on the parameters
  generate
    // R01 one of six ports
    if (PORT_NUM < 1 || PORT_NUM > smt_pkg::PORT_COUNT) begin : g_bad_port
      $error("port number out of range");
    end
    // R06 stretch bound
    if (TIMEOUT_CYCLES < 1 ||
        TIMEOUT_CYCLES * smt_pkg::CLK_PERIOD_NS > smt_pkg::STRETCH_MAX_NS) begin : g_bad_tmo
      $error("timeout cannot stay under the stretch limit");
    end
  endgenerate

  // ---------------- core domain ----------------

  smt_pkg::smt_core_s c_q; // whole byte engine state
  smt_pkg::smt_core_s c_d;
  logic [TW-1:0]      tmo_q; // cycles spent holding the clock
  logic [1:0]         pin_s; // synced {scl, sda}
  logic               ack_s; // synced ring answer toggle
  logic               ring_ack_tog_q;
  smt_pkg::smt_ring_rsp_s rsp_q; // ring answer, stable once the toggle lands

  // R05 pins pass two flops; idle bus reads high
  smt_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk   (clock),
    .rst_n (rst_n),
    .en    (ce),
    .d     ({scl, sda}),
    .q     (pin_s)
  );

  // ring answer toggle into the core domain
  smt_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
    .clk   (clock),
    .rst_n (rst_n),
    .en    (ce),
    .d     (ring_ack_tog_q),
    .q     (ack_s)
  );

  // edges and bus conditions seen on the synced pins
  wire logic scl_rise = pin_s[1] & ~c_q.scl_p;
  wire logic scl_fall = ~pin_s[1] & c_q.scl_p;
  // R03 start: data falls while clock high
  wire logic start_c  = pin_s[1] & c_q.scl_p & c_q.sda_p & ~pin_s[0];
  wire logic stop_c   = pin_s[1] & c_q.scl_p & ~c_q.sda_p & pin_s[0];
  wire logic [7:0] rx_byte = {c_q.sh[6:0], pin_s[0]};
  wire logic byte_end = scl_rise & (c_q.cnt == 4'h7);
  // a request left on the ring, even after a timeout, still counts
  wire logic inflight = ack_s ^ c_q.req_tog;
  // R08 busy answers NAK
  wire logic nak_busy = c_q.busy | inflight;
  wire logic tmo_hit  = (tmo_q == TW'(TIMEOUT_CYCLES - 1));
  // R04 fixed address match
  wire logic addr_hit = (rx_byte[7:1] == smt_pkg::OWN_ADDR);
  // R23 R21 R18 block size; pec bit ignored
  wire logic blk_new  = (rx_byte[1:0] == smt_pkg::SZ_DWORD);
  wire logic blk_cur  = (c_q.cmd[1:0] == smt_pkg::SZ_DWORD);

  // bytes needed before an access can run
  // R09 address bytes first
  function automatic logic [3:0] fld_need(input logic [7:0] cmd);
    return (cmd[3:2] == smt_pkg::OP_RD_DWORD) ? smt_pkg::FLD_ADDR_END : smt_pkg::FLD_ALL_END;
  endfunction : fld_need

  // byte sent at a given read answer position
  function automatic logic [7:0] tx_pick(input logic [2:0] idx, input logic [7:0] sts,
                                         input logic [31:0] rd);
    logic [7:0] b;
    b = smt_pkg::TX_FILL;
    unique case (idx)
      3'h0: b = smt_pkg::RD_BLOCK_LEN;
      3'h1: b = sts;
      3'h2: b = rd[31:24];
      3'h3: b = rd[23:16];
      3'h4: b = rd[15:8];
      3'h5: b = rd[7:0];
      default: b = smt_pkg::TX_FILL;
    endcase
    return b;
  endfunction : tx_pick

  // R22 read answer: status leads the data
  wire logic [2:0] tx_first = blk_cur ? smt_pkg::TX_IDX_LEN : smt_pkg::TX_IDX_STS;
  wire logic [2:0] tx_next  = (c_q.tx_idx == smt_pkg::TX_IDX_MAX) ? c_q.tx_idx : c_q.tx_idx + 3'h1;
  wire logic [7:0] tx_b0    = tx_pick(tx_first, c_q.sts, c_q.rdata);
  wire logic [7:0] tx_b1    = tx_pick(tx_next, c_q.sts, c_q.rdata);
  // R24 status of a finished access
  wire logic [7:0] sts_done = {2'h0, rsp_q.mabort, rsp_q.tabort, 3'h0,
                               ~rsp_q.mabort & ~rsp_q.tabort};

  // byte engine next state
  always_comb begin
    c_d       = c_q;
    c_d.scl_p = pin_s[1];
    c_d.sda_p = pin_s[0];
    if (start_c) begin
      // R05 a start anywhere restarts reception
      c_d.st       = smt_pkg::ST_RX;
      c_d.cnt      = 4'h0;
      c_d.is_addr  = 1'b1;
      // R26 nothing launches without a fresh command
      c_d.cmd_seen = 1'b0;
      c_d.launch   = 1'b0;
      c_d.sda_oe   = 1'b0;
    end else if (stop_c) begin
      // R05 stop ends whatever was under way
      c_d.st      = smt_pkg::ST_IDLE;
      c_d.is_addr = 1'b0;
      c_d.launch  = 1'b0;
      c_d.sda_oe  = 1'b0;
    end else begin
      unique case (c_q.st)
        smt_pkg::ST_IDLE: begin
          c_d.sda_oe = 1'b0;
        end
        // shifting in one byte
        smt_pkg::ST_RX: begin
          if (scl_rise) begin
            c_d.sh  = rx_byte;
            c_d.cnt = c_q.cnt + 4'h1;
          end
          if (byte_end && c_q.is_addr) begin
            // R03 answer only our own address
            c_d.ack   = addr_hit & ~nak_busy;
            c_d.rd    = rx_byte[0];
            c_d.phase = smt_pkg::PH_CMD;
            c_d.st    = smt_pkg::ST_ACK0;
          end else if (byte_end) begin
            c_d.ack = ~nak_busy;
            c_d.st  = smt_pkg::ST_ACK0;
            // R15 fields written only here, from the bus
            if (!nak_busy) begin
              unique case (c_q.phase)
                // R14 command comes first
                smt_pkg::PH_CMD: begin
                  c_d.cmd      = rx_byte;
                  c_d.cmd_seen = 1'b1;
                  // R16 first transfer restarts the fields
                  if (rx_byte[smt_pkg::CMD_BEGIN]) c_d.ptr = 4'h0;
                  c_d.phase = blk_new ? smt_pkg::PH_CNT : smt_pkg::PH_FLD;
                  // R07 command with end bit may launch
                  c_d.launch = rx_byte[smt_pkg::CMD_END] & ~rx_byte[smt_pkg::CMD_BEGIN] &
                               (c_q.ptr >= fld_need(rx_byte));
                end
                smt_pkg::PH_CNT: begin
                  c_d.len   = rx_byte;
                  c_d.phase = smt_pkg::PH_FLD;
                end
                smt_pkg::PH_FLD: begin
                  // R14 address 3..0, then data 3..0
                  if (c_q.ptr < smt_pkg::FLD_ALL_END) begin
                    c_d.fld[c_q.ptr[2:0]] = rx_byte;
                    c_d.ptr = c_q.ptr + 4'h1;
                    // R16 last transfer fires on its final byte
                    c_d.launch = c_q.cmd_seen & c_q.cmd[smt_pkg::CMD_END] &
                                 (c_q.ptr + 4'h1 == fld_need(c_q.cmd));
                  end
                end
                default: c_d.phase = smt_pkg::PH_CMD;
              endcase
            end
          end
        end
        // drive the acknowledge on the next low phase
        smt_pkg::ST_ACK0: begin
          if (scl_fall) begin
            c_d.sda_oe = c_q.ack;
            c_d.st     = smt_pkg::ST_ACK1;
          end
        end
        // acknowledge clocked out; decide what follows
        smt_pkg::ST_ACK1: begin
          if (scl_fall) begin
            c_d.sda_oe  = 1'b0;
            c_d.is_addr = 1'b0;
            c_d.cnt     = 4'h0;
            if (!c_q.ack) begin
              c_d.st = smt_pkg::ST_IDLE;
            end else if (c_q.launch) begin
              // R06 hold the clock low while the ring works
              c_d.st     = smt_pkg::ST_HOLD;
              c_d.scl_oe = 1'b1;
              c_d.busy   = 1'b1;
              c_d.launch = 1'b0;
            end else if (c_q.is_addr && c_q.rd) begin
              c_d.st     = smt_pkg::ST_TX;
              c_d.tx_idx = tx_first;
              c_d.sh     = {tx_b0[6:0], 1'b0};
              c_d.sda_oe = ~tx_b0[7];
              c_d.cnt    = 4'h1;
            end else begin
              c_d.st = smt_pkg::ST_RX;
            end
          end
        end
        // shifting out one byte, msb first
        smt_pkg::ST_TX: begin
          if (scl_fall) begin
            if (c_q.cnt == 4'h8) begin
              c_d.sda_oe = 1'b0;
              c_d.st     = smt_pkg::ST_MACK;
            end else begin
              c_d.sda_oe = ~c_q.sh[7];
              c_d.sh     = {c_q.sh[6:0], 1'b0};
              c_d.cnt    = c_q.cnt + 4'h1;
            end
          end
        end
        // master acknowledge: low asks for another byte
        smt_pkg::ST_MACK: begin
          if (scl_rise) c_d.mack = ~pin_s[0];
          if (scl_fall && c_q.mack) begin
            c_d.st     = smt_pkg::ST_TX;
            c_d.tx_idx = tx_next;
            c_d.sh     = {tx_b1[6:0], 1'b0};
            c_d.sda_oe = ~tx_b1[7];
            c_d.cnt    = 4'h1;
          end else if (scl_fall) begin
            c_d.st = smt_pkg::ST_IDLE;
          end
        end
        // clock held low; hand the access to the ring and wait
        smt_pkg::ST_HOLD: begin
          if (!c_q.issued && !inflight && !tmo_hit) begin
            c_d.req_tog = ~c_q.req_tog;
            c_d.issued  = 1'b1;
          end else if (c_q.issued && !inflight) begin
            // R22 success or abort flags from the ring
            c_d.sts    = sts_done;
            c_d.rdata  = rsp_q.rdata;
            c_d.issued = 1'b0;
            c_d.busy   = 1'b0;
            c_d.scl_oe = 1'b0;
            c_d.st     = smt_pkg::ST_RX;
          end else if (tmo_hit) begin
            // R13 give the bus back even if the ring never answers
            c_d.sts    = 8'h1 << smt_pkg::STS_TIMEOUT;
            c_d.issued = 1'b0;
            c_d.busy   = 1'b0;
            c_d.scl_oe = 1'b0;
            c_d.st     = smt_pkg::ST_RX;
          end
        end
        default: begin
          c_d.st     = smt_pkg::ST_IDLE;
          c_d.sda_oe = 1'b0;
          c_d.scl_oe = 1'b0;
        end
      endcase
    end
  end

  // engine state register
  always_ff @(posedge clock) begin
    if (!rst_n) c_q <= '0;
    else if (ce) c_q <= c_d;
  end

  // R06 hold timer, bounds the stretch
  always_ff @(posedge clock) begin
    if (!rst_n) tmo_q <= '0;
    else if (ce) tmo_q <= (c_q.st == smt_pkg::ST_HOLD && !tmo_hit) ? tmo_q + TW'(1) : '0;
  end

  // pin drivers and port role; the bus is only ever pulled low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scl_val      <= 1'b0;
      sda_val      <= 1'b0;
      scl_oe       <= 1'b0;
      sda_oe       <= 1'b0;
      busy         <= 1'b0;
      port_channel <= 2'h0;
      port_mem     <= 1'b0;
      port_hotplug <= 1'b0;
    end else if (ce) begin
      scl_val      <= 1'b0;
      sda_val      <= 1'b0;
      scl_oe       <= c_d.scl_oe;
      sda_oe       <= c_d.sda_oe;
      busy         <= c_d.busy;
      // R02 fixed role of this port
      port_channel <= 2'(PORT_NUM - 1);
      port_mem     <= (PORT_NUM <= smt_pkg::MEM_PORT_LAST);
      port_hotplug <= (PORT_NUM == smt_pkg::HOTPLUG_PORT);
    end
  end

  // ---------------- access formed from the fields ----------------

  // R19 operation and R17 address space
  wire logic [1:0]  op_w  = c_q.cmd[3:2];
  wire logic        cfg_w = c_q.cmd[smt_pkg::CMD_MODE];
  // R10 extended number widens offset to 4K; R11 filler byte gives offset bits 23:16
  wire logic [23:0] off_raw = cfg_w ? {12'h000, c_q.fld[2][3:0], c_q.fld[3]}
                                    : {c_q.fld[1], c_q.fld[2], c_q.fld[3]};
  // R20 natural alignment
  wire logic [23:0] off_al = (op_w == smt_pkg::OP_WR_BYTE) ? off_raw :
                             (op_w == smt_pkg::OP_WR_WORD) ? {off_raw[23:1], 1'b0} :
                             {off_raw[23:2], 2'h0};
  // R24 write data from the low bytes, copied to every lane
  wire logic [31:0] wd_w = (op_w == smt_pkg::OP_WR_BYTE) ? {4{c_q.fld[7]}} :
                           (op_w == smt_pkg::OP_WR_WORD) ? {2{c_q.fld[6], c_q.fld[7]}} :
                           {c_q.fld[4], c_q.fld[5], c_q.fld[6], c_q.fld[7]};
  // R25 region in 7:5, bus number in 4:0
  wire smt_pkg::smt_ring_cmd_s cmd_w = '{
    cfg:    cfg_w,
    region: c_q.fld[0][7:5],
    bus:    c_q.fld[0][4:0],
    dev:    c_q.fld[1][7:3],
    fn:     c_q.fld[1][2:0],
    offset: off_al,
    write:  (op_w != smt_pkg::OP_RD_DWORD),
    be:     smt_pkg::smt_byte_en(op_w, off_raw[1:0]),
    wdata:  wd_w
  };

  // ---------------- ring domain ----------------

  logic req_s;    // synced request toggle
  logic req_p_q;  // last seen toggle
  logic pend_q;   // request waiting for or holding the ring
  logic port_gnt; // ring granted to this port

  // request toggle into the ring domain; the fields stay still meanwhile
  smt_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync (
    .clk   (ring_clk),
    .rst_n (ring_rst_n),
    .en    (1'b1),
    .d     (c_q.req_tog),
    .q     (req_s)
  );

  wire logic req_new  = req_s ^ req_p_q;
  wire logic ring_end = ring_valid & ring_ack;

  // R12 share the ring with the host bus
  smt_ring_arb u_arb (
    .clk        (ring_clk),
    .rst_n      (ring_rst_n),
    .port_req   (pend_q),
    .port_done  (ring_end),
    .hbus_req   (hbus_req),
    .port_gnt_q (port_gnt),
    .hbus_gnt_q (hbus_gnt)
  );

  // capture the access, present it while granted, return the answer
  always_ff @(posedge ring_clk) begin
    if (!ring_rst_n) begin
      req_p_q        <= 1'b0;
      pend_q         <= 1'b0;
      ring_valid     <= 1'b0;
      ring_cmd       <= '0;
      rsp_q          <= '0;
      ring_ack_tog_q <= 1'b0;
    end else begin
      req_p_q <= req_s;
      if (req_new) begin
        pend_q   <= 1'b1;
        ring_cmd <= cmd_w;
      end
      ring_valid <= pend_q & port_gnt & ~ring_end & ~req_new;
      if (ring_end) begin
        pend_q         <= 1'b0;
        rsp_q          <= ring_rsp;
        ring_ack_tog_q <= ~ring_ack_tog_q;
      end
    end
  end

endmodule : smt_target_port
